// File: rtl/pmwc_pkg.sv
package pmwc_pkg;
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFF_SYS_CLK_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_FAST_OSC_CTRL = 8'h04;
  localparam logic [APB_AW-1:0] OFF_PORTA_WAKE = 8'h08;
  localparam logic [APB_AW-1:0] OFF_WDOG_CTRL = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h10;

  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 7;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam int FOSC_EN_BIT = 0;
  localparam int FOSC_STABLE_BIT = 1;
  localparam int WDT_WS_LSB = 0;
  localparam int WDT_WS_MSB = 2;
  localparam int WDT_WE_LSB = 3;
  localparam int WDT_WE_MSB = 7;
  localparam int STAT_PDF_BIT = 0;
  localparam int STAT_TO_BIT = 1;

  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic [2:0] SEL_RESET = 3'h1;
  localparam logic [4:0] WE_RESET = 5'h0A;
  localparam logic [2:0] WS_RESET = 3'h3;
  localparam logic FOSC_EN_RESET = 1'b1;

  localparam int WDT_W = 18;
  localparam logic [2:0] SWITCH_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    PMWC_RUN,
    PMWC_SLEEP,
    PMWC_STBY_SLOW,
    PMWC_STBY_BOTH,
    PMWC_STBY_FAST
  } pmwc_mode_e;

  function automatic logic [4:0] pmwc_wdt_bits(input logic [2:0] ws);
    logic [4:0] r;
    r = 5'h08;
    unique case (ws)
      3'h0: r = 5'h08;
      3'h1: r = 5'h0A;
      3'h2: r = 5'h0C;
      3'h3: r = 5'h0E;
      3'h4: r = 5'h0F;
      3'h5: r = 5'h10;
      3'h6: r = 5'h11;
      3'h7: r = 5'h12;
    endcase
    return r;
  endfunction : pmwc_wdt_bits
endpackage : pmwc_pkg

// File: rtl/pmwc_top.sv
`timescale 1ns/1ps
module pmwc_top #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmwc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_req,
  input wire logic clr_wdt_req,
  input wire logic [IRQ_W-1:0] irq_pending,
  input wire logic [IRQ_W-1:0] irq_enabled,
  input wire logic stack_full,
  input wire logic [PORT_W-1:0] porta_in,
  input wire logic slow_rc_clock,
  input wire logic slow_rc_stable,
  input wire logic fast_osc_ready,
  output logic [2:0] sysclk_active_select,
  output logic sysclk_is_slow,
  output logic fast_osc_run,
  output logic slow_osc_run,
  output logic cpu_stall,
  output logic io_hold,
  output logic resume_pulse,
  output logic irq_service_pulse,
  output logic pc_sp_reset_pulse,
  output logic wdt_reset_req,
  output pmwc_pkg::pmwc_mode_e power_mode
);
  import pmwc_pkg::*;

  localparam int NPIN = PORT_W + 3;

  logic [2:0] sel_reg;
  logic fast_keep_reg;
  logic slow_keep_reg;
  logic fosc_en_reg;
  logic fosc_stable_reg;
  logic [PORT_W-1:0] wake_en_reg;
  logic [4:0] wdt_we_reg;
  logic [2:0] wdt_ws_reg;
  logic pdf_reg;
  logic to_reg;
  logic [2:0] act_sel_reg;
  logic [2:0] sw_cnt_reg;
  logic [WDT_W-1:0] wdt_cnt_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  pmwc_mode_e mode_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic resume_reg;
  logic irq_srv_reg;
  logic pcsp_reg;
  logic wdt_rst_reg;
  logic [IRQ_W-1:0] irq_prev_reg;

  // pin synchronisers with agreement filter
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_flt;
  logic [NPIN-1:0] pin_flt_prev;

  assign pin_raw = {slow_rc_clock, slow_rc_stable, fast_osc_ready, porta_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_flt[gi] <= 1'b0;
          pin_flt_prev[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_flt[gi] <= pin_s3[gi];
          end
          pin_flt_prev[gi] <= pin_flt[gi];
        end
      end
    end
  endgenerate

  logic [PORT_W-1:0] porta_fall;
  logic fosc_ready_s;
  logic srco_stable_s;
  logic slow_tick;

  assign porta_fall = pin_flt_prev[PORT_W-1:0] & ~pin_flt[PORT_W-1:0];
  assign fosc_ready_s = pin_flt[PORT_W];
  assign srco_stable_s = pin_flt[PORT_W+1];
  assign slow_tick = pin_flt[PORT_W+2] & ~pin_flt_prev[PORT_W+2];

  // apb decode
  logic apb_setup;
  logic apb_done;
  logic wr_done;
  logic addr_ok;

  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & pready_reg;
  assign addr_ok = (paddr == OFF_SYS_CLK_CTRL) || (paddr == OFF_FAST_OSC_CTRL) ||
                   (paddr == OFF_PORTA_WAKE) || (paddr == OFF_WDOG_CTRL) ||
                   (paddr == OFF_STATUS);
  assign wr_done = apb_done & pwrite & addr_ok;

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      OFF_SYS_CLK_CTRL: begin
        rd_val[SEL_MSB:SEL_LSB] = sel_reg;
        rd_val[FAST_KEEP_BIT] = fast_keep_reg;
        rd_val[SLOW_KEEP_BIT] = slow_keep_reg;
      end
      OFF_FAST_OSC_CTRL: begin
        rd_val[FOSC_EN_BIT] = fosc_en_reg;
        rd_val[FOSC_STABLE_BIT] = fosc_stable_reg;
      end
      OFF_PORTA_WAKE: rd_val[PORT_W-1:0] = wake_en_reg;
      OFF_WDOG_CTRL: begin
        rd_val[WDT_WE_MSB:WDT_WE_LSB] = wdt_we_reg;
        rd_val[WDT_WS_MSB:WDT_WS_LSB] = wdt_ws_reg;
      end
      OFF_STATUS: begin
        rd_val[STAT_PDF_BIT] = pdf_reg;
        rd_val[STAT_TO_BIT] = to_reg;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_setup;
      if (apb_setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr_reg <= ~addr_ok;
      end else if (apb_done) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  logic halting;
  assign halting = halt_req && (mode_reg == PMWC_RUN);

  // software writes are held off while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= SEL_RESET;
      fast_keep_reg <= 1'b0;
      slow_keep_reg <= 1'b0;
      fosc_en_reg <= FOSC_EN_RESET;
      wake_en_reg <= '0;
      wdt_we_reg <= WE_RESET;
      wdt_ws_reg <= WS_RESET;
    end else if (wr_done && (mode_reg == PMWC_RUN)) begin
      unique case (paddr)
        OFF_SYS_CLK_CTRL: begin
          sel_reg <= pwdata[SEL_MSB:SEL_LSB];
          fast_keep_reg <= pwdata[FAST_KEEP_BIT];
          slow_keep_reg <= pwdata[SLOW_KEEP_BIT];
        end
        OFF_FAST_OSC_CTRL: fosc_en_reg <= pwdata[FOSC_EN_BIT];
        OFF_PORTA_WAKE: wake_en_reg <= pwdata[PORT_W-1:0];
        OFF_WDOG_CTRL: begin
          wdt_we_reg <= pwdata[WDT_WE_MSB:WDT_WE_LSB];
          wdt_ws_reg <= pwdata[WDT_WS_MSB:WDT_WS_LSB];
        end
        default: ;
      endcase
    end
  end

  // fast oscillator stable flag
  logic fosc_en_rise;
  assign fosc_en_rise = wr_done && (paddr == OFF_FAST_OSC_CTRL) && pwdata[FOSC_EN_BIT] &&
                        !fosc_en_reg && (mode_reg == PMWC_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fosc_stable_reg <= 1'b0;
    end else if (fosc_en_rise || !fosc_en_reg || !fast_osc_run) begin
      fosc_stable_reg <= 1'b0;
    end else if (fosc_ready_s) begin
      fosc_stable_reg <= 1'b1;
    end
  end

  // clock switch: delay, then wait for the target oscillator
  logic target_ok;
  assign target_ok = (sel_reg == SEL_SLOW) ? srco_stable_s : fosc_stable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_reg <= SEL_RESET;
      sw_cnt_reg <= 3'h0;
    end else if (sel_reg == act_sel_reg) begin
      sw_cnt_reg <= 3'h0;
    end else if (sw_cnt_reg < SWITCH_CYCLES) begin
      sw_cnt_reg <= sw_cnt_reg + 3'h1;
    end else if (target_ok) begin
      act_sel_reg <= sel_reg;
      sw_cnt_reg <= 3'h0;
    end
  end

  // watchdog counter on slow rc ticks
  logic [4:0] wdt_bits;
  logic wdt_ovf;
  assign wdt_bits = pmwc_wdt_bits(wdt_ws_reg);
  assign wdt_ovf = slow_tick && (wdt_cnt_reg == ((WDT_W'(1) << wdt_bits) - WDT_W'(1)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg <= '0;
    end else if (halting || clr_wdt_req || wdt_ovf) begin
      wdt_cnt_reg <= '0;
    end else if (slow_tick) begin
      wdt_cnt_reg <= wdt_cnt_reg + WDT_W'(1);
    end
  end

  // wake sources
  logic [IRQ_W-1:0] irq_new;
  logic pin_wake;
  logic irq_wake;
  logic irq_take;
  logic is_halted;

  assign is_halted = (mode_reg != PMWC_RUN);
  assign irq_new = irq_pending & ~irq_mask_reg & ~irq_prev_reg;
  assign pin_wake = |(porta_fall & wake_en_reg);
  assign irq_wake = |irq_new;
  assign irq_take = |(irq_new & irq_enabled) && !stack_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_reg <= '0;
    end else begin
      irq_prev_reg <= irq_pending;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= '0;
    end else if (halting) begin
      irq_mask_reg <= irq_pending;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= PMWC_RUN;
    end else if (halting) begin
      unique case ({fast_keep_reg, slow_keep_reg})
        2'b00: mode_reg <= PMWC_SLEEP;
        2'b01: mode_reg <= PMWC_STBY_SLOW;
        2'b11: mode_reg <= PMWC_STBY_BOTH;
        2'b10: mode_reg <= PMWC_STBY_FAST;
      endcase
    end else if (is_halted && (wdt_ovf || irq_wake || pin_wake)) begin
      mode_reg <= PMWC_RUN;
    end
  end

  // wake actions: watchdog over interrupt over pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_reg <= 1'b0;
      irq_srv_reg <= 1'b0;
      pcsp_reg <= 1'b0;
      wdt_rst_reg <= 1'b0;
    end else begin
      resume_reg <= 1'b0;
      irq_srv_reg <= 1'b0;
      pcsp_reg <= 1'b0;
      wdt_rst_reg <= wdt_ovf && !is_halted;
      if (is_halted) begin
        if (wdt_ovf) begin
          pcsp_reg <= 1'b1;
        end else if (irq_wake) begin
          irq_srv_reg <= irq_take;
          resume_reg <= !irq_take;
        end else if (pin_wake) begin
          resume_reg <= 1'b1;
        end
      end
    end
  end

  // status flags: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_reg <= 1'b0;
    end else if (halting) begin
      pdf_reg <= 1'b1;
    end else if (clr_wdt_req) begin
      pdf_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_reg <= 1'b0;
    end else if (wdt_ovf) begin
      to_reg <= 1'b1;
    end else if (halting) begin
      to_reg <= 1'b0;
    end
  end

  // oscillator run and stall outputs
  logic fast_run_next;
  logic slow_run_next;
  always_comb begin
    fast_run_next = fosc_en_reg;
    slow_run_next = 1'b1;
    if (mode_reg inside {PMWC_SLEEP, PMWC_STBY_SLOW}) begin
      fast_run_next = 1'b0;
    end
    if (mode_reg inside {PMWC_SLEEP, PMWC_STBY_FAST}) begin
      slow_run_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_run <= FOSC_EN_RESET;
      slow_osc_run <= 1'b1;
      cpu_stall <= 1'b0;
      io_hold <= 1'b0;
      sysclk_active_select <= SEL_RESET;
      sysclk_is_slow <= 1'b0;
    end else begin
      fast_osc_run <= fast_run_next;
      slow_osc_run <= slow_run_next;
      cpu_stall <= is_halted || halting;
      io_hold <= is_halted || halting;
      sysclk_active_select <= act_sel_reg;
      sysclk_is_slow <= (act_sel_reg == SEL_SLOW);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign resume_pulse = resume_reg;
  assign irq_service_pulse = irq_srv_reg;
  assign pc_sp_reset_pulse = pcsp_reg;
  assign wdt_reset_req = wdt_rst_reg;
  assign power_mode = mode_reg;

endmodule : pmwc_top

// File: dv/pmwc_osc_model.sv
`timescale 1ns/1ps
module pmwc_osc_model #(
  parameter int SLOW_HALF = 4,
  parameter int FAST_START = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fast_osc_run,
  output logic slow_rc_clock,
  output logic slow_rc_stable,
  output logic fast_osc_ready
);
  int slow_cnt;
  int fast_cnt;
  // slow rc runs free so the watchdog keeps ticking in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt <= 0;
      slow_rc_clock <= 1'b0;
      slow_rc_stable <= 1'b0;
    end else if (slow_cnt == SLOW_HALF - 1) begin
      slow_cnt <= 0;
      slow_rc_clock <= ~slow_rc_clock;
      slow_rc_stable <= 1'b1;
    end else begin
      slow_cnt <= slow_cnt + 1;
    end
  end
  // fast rc needs a restart time whenever it was stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt <= 0;
      fast_osc_ready <= 1'b0;
    end else if (!fast_osc_run) begin
      fast_cnt <= 0;
      fast_osc_ready <= 1'b0;
    end else if (fast_cnt < FAST_START) begin
      fast_cnt <= fast_cnt + 1;
    end else begin
      fast_osc_ready <= 1'b1;
    end
  end
endmodule : pmwc_osc_model

// File: dv/pmwc_monitor.sv
`timescale 1ns/1ps
module pmwc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmwc_pkg::APB_AW-1:0] paddr,
  input wire logic pready,
  input wire logic halt_req,
  input wire logic stack_full,
  input wire logic [2:0] sysclk_active_select,
  input wire logic fast_osc_run,
  input wire logic slow_osc_run,
  input wire logic cpu_stall,
  input wire logic io_hold,
  input wire logic resume_pulse,
  input wire logic irq_service_pulse,
  input wire logic pc_sp_reset_pulse,
  input wire pmwc_pkg::pmwc_mode_e power_mode
);
  import pmwc_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wake;
    power_mode != PMWC_RUN ##1 power_mode == PMWC_RUN;
  endsequence
  sequence s_sel_write;
    psel && penable && pready && pwrite && paddr == OFF_SYS_CLK_CTRL;
  endsequence
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb access not answered");
  chk_halt_enter: assert property (halt_req && power_mode == PMWC_RUN |=>
    cpu_stall && power_mode != PMWC_RUN) else $error("halt not taken");
  chk_halt_clocks: assert property (power_mode != PMWC_RUN |=>
    fast_osc_run == ($past(power_mode) inside {PMWC_STBY_BOTH, PMWC_STBY_FAST}) &&
    slow_osc_run == ($past(power_mode) inside {PMWC_STBY_SLOW, PMWC_STBY_BOTH}))
    else $error("oscillator state wrong in halted mode");
  chk_stall_hold: assert property (io_hold == cpu_stall &&
    (power_mode == PMWC_RUN || cpu_stall)) else $error("ports not held while halted");
  chk_wake_onehot: assert property (s_wake |->
    $onehot({resume_pulse, irq_service_pulse, pc_sp_reset_pulse}) ##1 !cpu_stall)
    else $error("wake without single resume action");
  chk_irq_service: assert property (irq_service_pulse |->
    $past(cpu_stall) && !$past(stack_full)) else $error("interrupt served badly");
  chk_resume_src: assert property (resume_pulse || pc_sp_reset_pulse |->
    $past(cpu_stall)) else $error("resume without halt");
  chk_sel_settle: assert property (s_sel_write |=>
    $stable(sysclk_active_select)[*3]) else $error("clock switched too early");
endmodule : pmwc_monitor

bind pmwc_top pmwc_monitor i_pmwc_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .halt_req, .stack_full, .sysclk_active_select, .fast_osc_run,
  .slow_osc_run, .cpu_stall, .io_hold, .resume_pulse, .irq_service_pulse,
  .pc_sp_reset_pulse, .power_mode);

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pmwc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic halt_req = 1'b0, clr_wdt_req = 1'b0, stack_full = 1'b0;
  logic [7:0] irq_pending = 8'h00, irq_enabled = 8'h00, porta_in = 8'hFF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slow_rc_clock, slow_rc_stable, fast_osc_ready, er;
  logic sysclk_is_slow, fast_osc_run, slow_osc_run, cpu_stall, io_hold;
  logic resume_pulse, irq_service_pulse, pc_sp_reset_pulse, wdt_reset_req;
  logic [2:0] sysclk_active_select, p, c;
  pmwc_mode_e power_mode;
  int failures = 0, comparisons = 0, r;

  pmwc_top i_pmwc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .halt_req, .clr_wdt_req, .irq_pending, .irq_enabled,
    .stack_full, .porta_in, .slow_rc_clock, .slow_rc_stable, .fast_osc_ready,
    .sysclk_active_select, .sysclk_is_slow, .fast_osc_run, .slow_osc_run, .cpu_stall,
    .io_hold, .resume_pulse, .irq_service_pulse, .pc_sp_reset_pulse,
    .wdt_reset_req, .power_mode);
  pmwc_osc_model i_pmwc_osc_model (.pclk, .presetn, .fast_osc_run, .slow_rc_clock,
    .slow_rc_stable, .fast_osc_ready);

  always #20 pclk = ~pclk;

  task automatic test_done();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle halt or clear-watchdog instruction
  task automatic pulse(input logic h);
    halt_req <= h;
    clr_wdt_req <= !h;
    @(posedge pclk);
    halt_req <= 1'b0;
    clr_wdt_req <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  task automatic wait_wake(input int lim, output logic [2:0] q);
    q = 3'h0;
    for (int i = 0; i < lim && q === 3'h0; i++) begin
      @(posedge pclk);
      q = {pc_sp_reset_pulse, irq_service_pulse, resume_pulse};
    end
  endtask : wait_wake

  function automatic pmwc_mode_e exp_mode(input logic [1:0] k);
    case (k)
      2'h0: return PMWC_SLEEP;
      2'h1: return PMWC_STBY_SLOW;
      2'h3: return PMWC_STBY_BOTH;
      default: return PMWC_STBY_FAST;
    endcase
  endfunction : exp_mode

  initial begin
    r = $urandom(32'h221A);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_SYS_CLK_CTRL, 0);
    chk("sys_ctrl", 32'h20, rd);
    apb(1'b0, OFF_WDOG_CTRL, 0);
    chk("wdog_ctrl", 32'h53, rd);
    apb(1'b0, OFF_STATUS, 0);
    chk("status", 0, rd);
    apb(1'b1, 8'h14, 0);
    chk("slverr", 1, er);
    apb(1'b1, OFF_FAST_OSC_CTRL, 0);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFF_FAST_OSC_CTRL, 0);
    chk("fosc_off", 0, rd);
    apb(1'b1, OFF_FAST_OSC_CTRL, 1);
    apb(1'b0, OFF_FAST_OSC_CTRL, 0);
    chk("fosc_wait", 1, rd);
    repeat (60) @(posedge pclk);
    apb(1'b0, OFF_FAST_OSC_CTRL, 0);
    chk("fosc_ok", 3, rd);
    r = $urandom_range(7, 0);
    for (int i = 0; i < 9; i++) begin
      c = (i == 8) ? 3'h1 : 3'(r + i);
      apb(1'b1, OFF_SYS_CLK_CTRL, {24'h0, c, 5'h00});
      for (int n = 0; n < 300 && sysclk_active_select !== c; n++)
        @(posedge pclk);
      @(posedge pclk);
      chk("active_sel", c, sysclk_active_select);
      chk("is_slow", c == SEL_SLOW, sysclk_is_slow);
    end
    for (int k = 0; k < 4; k++) begin
      r = $urandom_range(7, 0);
      apb(1'b1, OFF_PORTA_WAKE, 32'h1 << r);
      apb(1'b1, OFF_SYS_CLK_CTRL, 32'h20 | k);
      pulse(1'b1);
      chk("mode", exp_mode(2'(k)), power_mode);
      apb(1'b0, OFF_STATUS, 0);
      chk("status_halt", 1, rd);
      porta_in[3'(r + 1)] <= 1'b0;
      wait_wake(20, p);
      chk("masked_pin", 0, p);
      porta_in[r] <= 1'b0;
      wait_wake(20, p);
      chk("pin_wake", 1, p);
      porta_in <= 8'hFF;
      repeat (8) @(posedge pclk);
    end
    for (int j = 0; j < 3; j++) begin
      irq_enabled <= (8'($urandom) | 8'h02) & ((j == 1) ? 8'hFD : 8'hFF);
      stack_full <= (j == 2);
      irq_pending <= 8'h01;
      @(posedge pclk);
      pulse(1'b1);
      wait_wake(20, p);
      chk("stale_irq", 0, p);
      irq_pending <= 8'h03;
      wait_wake(20, p);
      chk("irq_wake", (j == 0) ? 2 : 1, p);
      irq_pending <= 8'h00;
      repeat (4) @(posedge pclk);
    end
    pulse(1'b0);
    apb(1'b1, OFF_WDOG_CTRL, 32'h50);
    repeat (1600) @(posedge pclk);
    pulse(1'b1);
    wait_wake(1400, p);
    chk("wdt_cleared", 0, p);
    wait_wake(1000, p);
    chk("wdt_wake", 4, p);
    apb(1'b0, OFF_STATUS, 0);
    chk("status_wdt", 3, rd);
    pulse(1'b0);
    apb(1'b0, OFF_STATUS, 0);
    chk("pdf_clear", 0, rd[0]);
    for (r = 0; r < 2200 && wdt_reset_req !== 1'b1; r++)
      @(posedge pclk);
    chk("wdt_run_ovf", 1, wdt_reset_req);
    chk("wdt_run_span", 1, r > 1900);
    test_done();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    test_done();
  end
endmodule : tb_top
